// ---- src/asf_pkg.sv ----
// asf_pkg: constants shared by the serial frame interface of a sar converter
// assumes a 50 mhz system clock; all pin timings are counted in its cycles
package asf_pkg;

   // clock and pin-pulse timing
   localparam int CLK_NS = 20;
   localparam int RST_MIN_NS = 40;
   localparam int PD_MIN_NS = 400;
   localparam int RST_MIN_CYC = (RST_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int PD_MIN_CYC = (PD_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int PULSE_CW = 5;

   // internal conversion time, kept by the local oscillator (system clock)
   localparam int CONV_NS = 2000;
   localparam int CONV_CYC = CONV_NS / CLK_NS;

   // frame geometry
   localparam int CFG_W = 16;
   localparam int RES_W = 12;
   localparam int SR_W = 24;
   localparam int CNT_W = 6;
   localparam logic [CNT_W-1:0] MSB_EDGE = 6'h10;
   localparam logic [CNT_W-1:0] LAST_IN = 6'h0f;

   // configuration word fields
   localparam int CMD_LSB = 13;
   localparam int CMD_W = 3;
   localparam int CH_LSB = 10;
   localparam int CH_W = 3;
   localparam int FMT_BIT = 0;
   localparam logic [CMD_W-1:0] MANUAL_CHANNEL_CMD = 3'h6;
   localparam logic [CFG_W-1:0] CFG_DEFAULT = 16'h0000;
   // idle pin levels {reset pin, chain, data in, serial clock, select}
   localparam logic [4:0] PIN_IDLE = 5'h13;

   // frame state, one-hot
   typedef enum logic [2:0] {
      FR_IDLE = 3'b001,
      FR_ACTIVE = 3'b010,
      FR_PD = 3'b100
   } asf_fr_t;

endpackage

// ---- src/asf_pair_buf.sv ----
// asf_pair_buf: small valid/ready fifo for conversion results
// assumes both sides on clk; default depth of two holds one stalled word
`timescale 1ns/1ns
`default_nettype none
module asf_pair_buf
   import asf_pkg::*;
#(
   parameter int W = 12,
   parameter int DEPTH = 2
)(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] cnt;
   } asf_buf_t;

   asf_buf_t s;
   asf_buf_t next_s;
   logic push;
   logic pop;

   // full and empty come straight from the occupancy count
   assign in_ready = (s.cnt != (AW+1)'(DEPTH));
   assign out_valid = (s.cnt != '0);
   assign out_data = s.mem[s.rd];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // pointer wrap works for any depth, not only powers of two
   always_comb
   begin
      next_s = s;
      if (push)
      begin
         next_s.mem[s.wr] = in_data;
         next_s.wr = (s.wr == AW'(DEPTH - 1)) ? '0 : s.wr + 1'b1;
      end
      if (pop)
         next_s.rd = (s.rd == AW'(DEPTH - 1)) ? '0 : s.rd + 1'b1;
      if (push && !pop)
         next_s.cnt = s.cnt + 1'b1;
      else if (pop && !push)
         next_s.cnt = s.cnt - 1'b1;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
         s <= '0;
      else
         s <= next_s;
   end
endmodule // asf_pair_buf
`default_nettype wire

// ---- src/asf_pulse_meter.sv ----
// asf_pulse_meter: measures low pulses on the reset/power-down pin
// assumes pin_low is already synchronised to clk
`timescale 1ns/1ns
`default_nettype none
module asf_pulse_meter
   import asf_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic pin_low,
   output logic cfg_clear,
   output logic power_down_state
);
   typedef struct packed {
      logic [PULSE_CW-1:0] cnt;
      logic clr;
      logic pd;
   } asf_pm_t;

   asf_pm_t s;
   asf_pm_t next_s;

   assign cfg_clear = s.clr;
   assign power_down_state = s.pd;

   // the clear fires while the pin is still low, so it acts at any moment;
   // pulses of 2 samples or fewer are treated as glitches
   always_comb
   begin
      next_s = s;
      next_s.clr = 1'b0;
      if (pin_low)
      begin
         if (s.cnt != PULSE_CW'(PD_MIN_CYC))
            next_s.cnt = s.cnt + 1'b1;
         next_s.clr = (s.cnt == PULSE_CW'(RST_MIN_CYC)); // [RL17]
         next_s.pd = (next_s.cnt == PULSE_CW'(PD_MIN_CYC)); // [RL18]
      end
      else
      begin
         next_s.cnt = '0;
         next_s.pd = 1'b0;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
         s <= '0;
      else
         s <= next_s;
   end
endmodule // asf_pulse_meter
`default_nettype wire

// ---- src/asf_frame_if.sv ----
// asf_frame_if: serial frame interface of a multichannel sar converter
// assumes pins arrive asynchronously and are sampled by clk (50 mhz);
// conversion results come from the analog side over a valid/ready stream
`timescale 1ns/1ns
`default_nettype none
// Contract
// [RL1] chip-select fall starts frame and conversion (code converts only after a manual channel command)
// [RL2] converted channel comes from previous frame
// [RL3] chip select high keeps interface idle
// [RL4] all actions on serial clock falling edges
// [RL5] sixteen input bits captured after frame start
// [RL6] new configuration applies at next frame
// [RL7] output driven low through fifteen edges
// [RL8] sixteenth edge launches result msb
// [RL9] host samples bit one edge later
// [RL10] zeros after result until next conversion
// [RL11] output released when chip select rises
// [RL12] last input bit at edge sixteen
// [RL13] host waits conversion before edge sixteen
// [RL14] conversion timed by internal clock
// [RL15] output frame length follows format setting
// [RL16] first chain input held low by host
// [RL17] short reset pulse clears configuration only
// [RL18] long low pulse enters power-down, defaults
// [RL19] host avoids pulses between both limits
// [RL20] reset pin acts at any time
// [RL21] power-down ignores other digital inputs
// [RL22] host writes configuration then command first
// [RL23] chain input shifted in after edge sixteen
// [RL24] all-zero word keeps previous configuration
// [RL25] input word arrives msb first
module asf_frame_if
   import asf_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic cs_b,
   input wire logic sclk,
   input wire logic sdi,
   input wire logic daisy,
   input wire logic reset_powerdown_pin_b,
   input wire logic res_valid,
   output logic res_ready,
   input wire logic [RES_W-1:0] res_data,
   output logic sdo,
   output logic sdo_oe,
   output logic conv_start,
   output logic [CH_W-1:0] conv_channel,
   output logic power_down_state
);
   localparam int CV_W = $clog2(CONV_CYC + 1);

   typedef struct packed {
      logic [4:0] sync1;
      logic [4:0] sync2;
      logic cs_prev;
      logic sclk_prev;
      asf_fr_t fr;
      logic [CNT_W-1:0] bit_cnt;
      logic [CFG_W-1:0] in_sr;
      logic [CFG_W-1:0] pend_cfg;
      logic [CFG_W-1:0] act_cfg;
      logic [SR_W-1:0] out_sr;
      logic sdo;
      logic sdo_oe;
      logic [CV_W-1:0] conv_cnt;
      logic conv_busy;
      logic conv_start;
      logic [CH_W-1:0] conv_channel;
      logic running;
   } asf_st_t;

   // synchronisers start at the idle pin levels, so reset leaves no false edge
   localparam asf_st_t ST_RST = '{fr: FR_IDLE, sync1: PIN_IDLE, sync2: PIN_IDLE,
                                  cs_prev: 1'b1, sclk_prev: 1'b1, default: '0};

   asf_st_t s;
   asf_st_t next_s;
   logic cs_high;
   logic cs_fall;
   logic sclk_fall;
   logic sdi_s;
   logic daisy_s;
   logic pd;
   logic cfg_clear;
   logic buf_valid;
   logic buf_pop;
   logic [RES_W-1:0] buf_data;
   logic msb_now;

   ////////////////////////////////////////////////////////////////////////
   // helpers

   // the bit on the wire is the top of the active window of the shifter
   function automatic logic out_bit(input logic [SR_W-1:0] sr, input logic wide);
      out_bit = wide ? sr[SR_W-1] : sr[CFG_W-1];
   endfunction

   function automatic logic [CH_W-1:0] chan_of(input logic [CFG_W-1:0] cfg);
      chan_of = cfg[CH_LSB +: CH_W];
   endfunction

   // short format: 12 result bits and 4 zeros; wide format appends channel
   function automatic logic [SR_W-1:0] load_word(input logic [RES_W-1:0] r,
                                                 input logic wide,
                                                 input logic [CH_W-1:0] ch);
      if (wide)
         load_word = {r, 4'h0, 5'h00, ch};
      else
         load_word = {8'h00, r, 4'h0};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // pin sampling and edge finding (only the second flops are read)

   assign cs_high = s.sync2[0];
   assign cs_fall = s.cs_prev && !s.sync2[0];
   assign sclk_fall = s.sclk_prev && !s.sync2[1]; // [RL4]
   assign sdi_s = s.sync2[2];
   assign daisy_s = s.sync2[3];
   assign msb_now = out_bit(s.out_sr, s.act_cfg[FMT_BIT]);

   ////////////////////////////////////////////////////////////////////////
   // reset pin classifier and result buffer

   asf_pulse_meter u_meter (
      .clk(clk),
      .rst_b(rst_b),
      .pin_low(!s.sync2[4]),
      .cfg_clear(cfg_clear),
      .power_down_state(pd)
   );

   // the buffer keeps a result that lands while the previous one waits
   asf_pair_buf #(.W(RES_W), .DEPTH(2)) u_buf (
      .clk(clk),
      .rst_b(rst_b),
      .in_valid(res_valid),
      .in_ready(res_ready),
      .in_data(res_data),
      .out_valid(buf_valid),
      .out_ready(buf_pop),
      .out_data(buf_data)
   );

   // the shifter takes a result only at the end of the conversion time
   assign buf_pop = s.conv_busy && (s.conv_cnt == CV_W'(1)) && !pd;

   assign sdo = s.sdo;
   assign sdo_oe = s.sdo_oe;
   assign conv_start = s.conv_start;
   assign conv_channel = s.conv_channel;
   assign power_down_state = pd;

   ////////////////////////////////////////////////////////////////////////
   // next-state logic

   always_comb
   begin
      next_s = s;
      next_s.sync1 = {reset_powerdown_pin_b, daisy, sdi, sclk, cs_b};
      next_s.sync2 = s.sync1;
      next_s.cs_prev = s.sync2[0];
      next_s.sclk_prev = s.sync2[1];
      next_s.conv_start = 1'b0;

      // conversion timer runs off clk, never off the serial clock
      if (s.conv_busy)
      begin
         next_s.conv_cnt = s.conv_cnt - 1'b1; // [RL14]
         if (s.conv_cnt == CV_W'(1))
         begin
            next_s.conv_busy = 1'b0;
            // an empty buffer leaves zeros, a stale word is never reused
            next_s.out_sr = load_word(buf_valid ? buf_data : '0,
                                      s.act_cfg[FMT_BIT],
                                      chan_of(s.act_cfg)); // [RL15] [RL23]
         end
      end

      unique case (s.fr)
         FR_IDLE:
         begin
            next_s.sdo = 1'b0;
            next_s.sdo_oe = 1'b0; // [RL3] [RL11]
            if (cs_fall)
            begin
               // the word from the last frame becomes active only now
               next_s.act_cfg = s.pend_cfg; // [RL6]
               if (s.pend_cfg[CMD_LSB +: CMD_W] == MANUAL_CHANNEL_CMD)
                  next_s.running = 1'b1;
               if (next_s.running)
               begin
                  next_s.conv_start = 1'b1; // [RL1]
                  next_s.conv_channel = chan_of(s.pend_cfg); // [RL2]
                  next_s.conv_busy = 1'b1;
                  next_s.conv_cnt = CV_W'(CONV_CYC);
               end
               else
                  next_s.out_sr = '0; // [RL10]
               next_s.bit_cnt = '0;
               next_s.sdo_oe = 1'b1; // [RL7]
               next_s.fr = FR_ACTIVE;
            end
         end
         FR_ACTIVE:
         begin
            if (cs_high)
            begin
               next_s.sdo = 1'b0;
               next_s.sdo_oe = 1'b0; // [RL11]
               next_s.fr = FR_IDLE;
            end
            else if (sclk_fall)
            begin
               if (s.bit_cnt != '1)
                  next_s.bit_cnt = s.bit_cnt + 1'b1;
               if (s.bit_cnt < MSB_EDGE)
               begin
                  next_s.in_sr = {s.in_sr[CFG_W-2:0], sdi_s}; // [RL5] [RL25]
                  next_s.sdo = 1'b0; // [RL7]
               end
               if (s.bit_cnt == LAST_IN)
               begin
                  // an all-zero word keeps the present setting
                  if ({s.in_sr[CFG_W-2:0], sdi_s} != '0)
                     next_s.pend_cfg = {s.in_sr[CFG_W-2:0], sdi_s}; // [RL12] [RL24]
                  next_s.sdo = msb_now; // [RL8]
               end
               else if (s.bit_cnt >= MSB_EDGE)
               begin
                  // chain data fills from below, so a lone device sends zeros
                  next_s.out_sr = {s.out_sr[SR_W-2:0], daisy_s}; // [RL23] [RL10]
                  next_s.sdo = out_bit(next_s.out_sr, s.act_cfg[FMT_BIT]);
               end
            end
         end
         FR_PD:
         begin
            next_s.sdo = 1'b0;
            next_s.sdo_oe = 1'b0;
            if (!pd)
               next_s.fr = FR_IDLE;
         end
         default:
            next_s.fr = FR_IDLE;
      endcase

      // power-down overrides every other pin; clear acts mid-frame too
      if (cfg_clear)
      begin
         next_s.pend_cfg = CFG_DEFAULT; // [RL17] [RL20]
         next_s.act_cfg = CFG_DEFAULT;
         next_s.running = 1'b0;
      end
      if (pd)
      begin
         next_s.fr = FR_PD; // [RL21]
         next_s.sdo = 1'b0;
         next_s.sdo_oe = 1'b0;
         next_s.conv_busy = 1'b0;
         next_s.conv_start = 1'b0;
         next_s.act_cfg = CFG_DEFAULT; // [RL18]
         next_s.pend_cfg = CFG_DEFAULT;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
         s <= ST_RST;
      else
         s <= next_s;
   end

   ////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   a_idle_no_drive: assert property (s.fr != FR_ACTIVE |-> !s.sdo_oe) // [RL3]
      else $error("sdo driven outside a frame");

   a_cs_rise_hiz: assert property ( // [RL11]
      s.fr == FR_ACTIVE && cs_high |=> !s.sdo_oe)
      else $error("sdo not released after chip select rose");

   a_early_low: assert property ( // [RL7]
      s.fr == FR_ACTIVE && s.bit_cnt < MSB_EDGE |-> !s.sdo)
      else $error("sdo not low before sixteenth edge");

   a_msb_launch: assert property ( // [RL8]
      s.fr == FR_ACTIVE && !cs_high && sclk_fall && s.bit_cnt == LAST_IN && !pd
      |=> s.sdo == $past(msb_now) && s.bit_cnt == MSB_EDGE)
      else $error("msb not launched on sixteenth edge");

   a_start_pulse: assert property ( // [RL1]
      $rose(s.conv_start) |-> s.fr == FR_ACTIVE && s.bit_cnt == '0
      && s.conv_busy ##1 !s.conv_start)
      else $error("conversion start not tied to frame start");

   // a pin clear landing on the start edge wipes the settings, so skip that case
   a_chan_prev: assert property ( // [RL2]
      s.conv_start && !$past(cfg_clear) |-> s.conv_channel == chan_of(s.act_cfg)
      && s.act_cfg == $past(s.pend_cfg))
      else $error("converted channel not from previous frame");

   a_cfg_frozen: assert property ( // [RL6]
      $changed(s.act_cfg) |-> $past(s.fr == FR_IDLE && cs_fall) || $past(cfg_clear)
      || $past(pd))
      else $error("configuration changed inside a frame");

   a_sdi_ignored: assert property ( // [RL12]
      s.fr == FR_ACTIVE && s.bit_cnt >= MSB_EDGE |=> $stable(s.in_sr))
      else $error("input captured after sixteenth edge");

   a_word_taken: assert property ( // [RL5]
      s.fr == FR_ACTIVE && !cs_high && sclk_fall && s.bit_cnt == LAST_IN && !cfg_clear
      && !pd && {s.in_sr[CFG_W-2:0], sdi_s} != '0
      |=> s.pend_cfg == $past({s.in_sr[CFG_W-2:0], sdi_s}))
      else $error("input word not taken at sixteenth edge");

   a_zero_keep: assert property ( // [RL24]
      s.fr == FR_ACTIVE && !cs_high && sclk_fall && s.bit_cnt == LAST_IN && !cfg_clear
      && !pd && {s.in_sr[CFG_W-2:0], sdi_s} == '0 |=> $stable(s.pend_cfg))
      else $error("all-zero word changed the configuration");

   a_chain_shift: assert property ( // [RL23]
      s.fr == FR_ACTIVE && !cs_high && sclk_fall && s.bit_cnt >= MSB_EDGE && !pd
      |=> s.out_sr[0] == $past(daisy_s))
      else $error("chain input not shifted in");

   a_pin_clear: assert property ( // [RL17]
      cfg_clear |=> s.pend_cfg == CFG_DEFAULT && !s.running)
      else $error("short reset pulse kept the configuration");

   a_pd_quiet: assert property ( // [RL21]
      pd |=> !s.sdo_oe && !s.conv_start && s.act_cfg == CFG_DEFAULT)
      else $error("activity or settings kept in power-down");

   // for the first 8 cycles after the start only power-down may cut a conversion short
   a_conv_time: assert property ($rose(s.conv_busy) |-> s.conv_cnt == CV_W'(CONV_CYC) // [RL14]
      ##1 (s.conv_busy || $past(pd))[*8])
      else $error("conversion ended too early");

endmodule // asf_frame_if
`default_nettype wire

// ---- verification/asf_host_model.sv ----
// asf_host_model: host controller that runs frames on the serial link
// assumes clk is the bench system clock; pins change only at its falling edge
`timescale 1ns/1ns
`default_nettype none
module asf_host_model
   import asf_pkg::*;
(
   input wire logic clk,
   input wire logic sdo,
   input wire logic sdo_oe,
   output logic cs_b,
   output logic sclk,
   output logic sdi,
   output logic daisy
);
   logic line;

   // no pull on the data line, so a released pin reads as z and never matches
   assign line = sdo_oe ? sdo : 1'bz;

   // link idles with select high and serial clock parked high
   initial
   begin
      cs_b = 1'b1;
      sclk = 1'b1;
      sdi = 1'b0;
      daisy = 1'b0;
   end

   task automatic wait_clk(input int n);
      repeat (n) @(negedge clk);
   endtask

   // one frame: serial clock period of 8 clk keeps edge 16 well past conversion
   task automatic frame(input logic [15:0] word, input int falls, input logic [31:0] dz,
                        input logic late, output logic [63:0] rx);
      rx = '0;
      @(negedge clk);
      cs_b = 1'b0;
      sdi = word[15];
      for (int k = 1; k <= falls; k++)
      begin
         wait_clk(4);
         if (k > 1)
            rx = {rx[62:0], line};
         sclk = 1'b0;
         wait_clk(4);
         sclk = 1'b1;
         sdi = (k < 16) ? word[15-k] : late;
         daisy = (k >= 16 && k < 48) ? dz[31-(k-16)] : 1'b0;
      end
      wait_clk(4);
      rx = {rx[62:0], line};
      cs_b = 1'b1;
      sdi = 1'b0;
      daisy = 1'b0;
      wait_clk(8);
   endtask
endmodule // asf_host_model
`default_nettype wire

// ---- verification/tb_adc_serial_frame_interface.sv ----
// tb_adc_serial_frame_interface: self-checking bench for the frame interface
// assumes asf_pkg and the design files are compiled first
`timescale 1ns/1ns
`default_nettype none
module tb_adc_serial_frame_interface;
   import asf_pkg::*;
   logic clk, rst_b, cs_b, sclk, sdi, daisy, pin_b, res_valid, res_ready;
   logic sdo, sdo_oe, conv_start, power_down_state;
   logic [RES_W-1:0] res_data;
   logic [CH_W-1:0] conv_channel;
   logic [CH_W-1:0] last_ch;
   int num_errors = 0;
   int cmp_count = 0;
   int n_conv = 0;
   logic [63:0] rx;
   localparam logic [31:0] DZ = 32'hb6d0_0000;

   ////////////////////////////////////////////////////////////////////////////
   asf_frame_if asf_frame_if_inst (.clk(clk), .rst_b(rst_b), .cs_b(cs_b), .sclk(sclk),
      .sdi(sdi), .daisy(daisy), .reset_powerdown_pin_b(pin_b), .res_valid(res_valid),
      .res_ready(res_ready), .res_data(res_data), .sdo(sdo), .sdo_oe(sdo_oe),
      .conv_start(conv_start), .conv_channel(conv_channel),
      .power_down_state(power_down_state));
   asf_host_model asf_host_model_inst (.clk(clk), .sdo(sdo), .sdo_oe(sdo_oe), .cs_b(cs_b),
      .sclk(sclk), .sdi(sdi), .daisy(daisy));

   // 50 mhz system clock
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // count conversion starts and keep the channel; read at the falling edge, where
   // the registered pulse has settled
   always @(negedge clk)
      if (conv_start === 1'b1)
      begin
         n_conv <= n_conv + 1;
         last_ch <= conv_channel;
      end

   ////////////////////////////////////////////////////////////////////////////
   task automatic close_out();
      $display("comparisons %0d errors %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic check_bit(input logic got, input logic exp);
      cmp_count++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[ERR] t=%0t got %0h exp %0h", $time, got, exp);
      end
   endtask

   task automatic check_vec(input logic [63:0] got, input logic [63:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[ERR] t=%0t got %0h exp %0h", $time, got, exp);
      end
   endtask

   // one frame, then the shifted-out bits, start count, channel and release
   task automatic run_frame(input logic [15:0] w, input int falls, input logic [31:0] dz,
                            input logic late, input logic [63:0] exp_rx, input int exp_n,
                            input logic [2:0] exp_ch);
      int n0;
      n0 = n_conv;
      asf_host_model_inst.frame(w, falls, dz, late, rx);
      check_vec(rx, exp_rx);
      check_vec(64'(n_conv - n0), 64'(exp_n));
      if (exp_n > 0)
         check_vec({61'h0, last_ch}, {61'h0, exp_ch});
      check_bit(sdo_oe, 1'b0);
   endtask

   // offer one word; valid and data stay put until ready is seen high
   task automatic push(input logic [11:0] d);
      int i;
      @(negedge clk);
      res_valid = 1'b1;
      res_data = d;
      i = 0;
      // ready comes from a registered count, so it is settled at the falling edge
      while (res_ready !== 1'b1 && i < 2000)
      begin
         @(negedge clk);
         i++;
      end
      if (i >= 2000)
      begin
         num_errors++;
         close_out();
      end
      @(posedge clk);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // first frame writes manual command, channel 5; nothing converts yet
   task automatic sc_first_config();
      check_bit(sdo_oe, 1'b0);
      run_frame(16'hd400, 20, 32'h0, 1'b0, 64'h0, 0, 3'h0);
   endtask

   // fill the buffer to refusal, then drain it across three converting frames
   task automatic sc_stream_frames();
      push(12'ha5c);
      push(12'h3e1);
      @(negedge clk);
      res_data = 12'h7b2;
      check_bit(res_ready, 1'b0);
      fork
         run_frame(16'hd801, 40, DZ, 1'b0, {12'ha5c, 4'h0, 9'h16d}, 1, 3'h5);
         push(12'h7b2);
      join
      @(negedge clk);
      res_valid = 1'b0;
      run_frame(16'h0000, 48, DZ, 1'b1, {12'h3e1, 9'h0, 3'h6, 9'h16d}, 1, 3'h6);
      run_frame(16'hc400, 48, DZ, 1'b0, {12'h7b2, 9'h0, 3'h6, 9'h16d}, 1, 3'h6);
   endtask

   // 80 ns pulse clears pending config, stays out of power-down
   task automatic sc_pin_reset();
      @(negedge clk);
      pin_b = 1'b0;
      repeat (4) @(negedge clk);
      pin_b = 1'b1;
      repeat (6) @(negedge clk);
      check_bit(power_down_state, 1'b0);
      run_frame(16'h0000, 20, 32'h0, 1'b0, 64'h0, 0, 3'h0);
   endtask

   // 3960 ns pulse enters power-down; a frame sent meanwhile is ignored
   task automatic sc_power_down();
      @(negedge clk);
      pin_b = 1'b0;
      repeat (25) @(negedge clk);
      check_bit(power_down_state, 1'b1);
      fork
         asf_host_model_inst.frame(16'hc401, 20, DZ, 1'b0, rx);
         begin
            repeat (40) @(negedge clk);
            check_bit(sdo_oe, 1'b0);
         end
      join
      pin_b = 1'b1;
      repeat (6) @(negedge clk);
      check_bit(power_down_state, 1'b0);
      run_frame(16'h0000, 20, 32'h0, 1'b0, 64'h0, 0, 3'h0);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      rst_b = 1'b0;
      pin_b = 1'b1;
      res_valid = 1'b0;
      res_data = 12'h000;
      repeat (5) @(negedge clk);
      rst_b = 1'b1;
      repeat (4) @(negedge clk);
      sc_first_config();
      sc_stream_frames();
      sc_pin_reset();
      sc_power_down();
      close_out();
   end

   // watchdog: the whole run needs about 1900 clk
   initial
   begin
      repeat (20000) @(posedge clk);
      num_errors++;
      close_out();
   end
endmodule // tb_adc_serial_frame_interface
`default_nettype wire
